/* File: design/fill_counter.sv */
// Byte count of the data set currently being filled
`timescale 1ns/1ps
module fill_counter
	import tx_flags_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	fill_if.cnt       port
);

	logic [SIZE_W-1:0] count;

	// Counts bytes; holds at the size so a full set never wraps
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count <= '0;
		end else if (port.restart) begin
			count <= '0;
		end else if (port.byte_write && !port.full) begin
			count <= count + SIZE_W'(1);
		end
	end

	assign port.empty = (count == '0);
	assign port.full  = (count >= port.fifo_size);

endmodule

/* File: design/fill_if.sv */
// Carrier between the flag block and its byte fill counter
`timescale 1ns/1ps
interface fill_if;
	import tx_flags_pkg::*;
	logic              byte_write;
	logic              restart;
	logic [SIZE_W-1:0] fifo_size;
	logic              empty;
	logic              full;

	modport ctl (output byte_write, output restart, output fifo_size, input empty, input full);
	modport cnt (input byte_write, input restart, input fifo_size, output empty, output full);
endinterface

/* File: design/tx_fifo_flags.sv */
// Transmit FIFO status flags with frame-aligned data-set visibility
//
// Behaviour
// - Index field bits 7:6 read only
// - Feature mode: new set visible at next SOF
// - Before SOF answer IN with zero-length packet
// - Late set gives zero-length packet that frame
// - Late set dropped at second SOF if newer set held
// - Bits 5:4 reserved, read zero
// - Empty flag high while current set unwritten
// - Empty flag updates immediately in all modes
// - Full flag set when count reaches size
// - Full flag clears when count below size
// - Iso: USB side changes now, firmware at SOF
// - Count write at index 11 sets overrun
`timescale 1ns/1ps
module tx_fifo_flags
	import tx_flags_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              fifo_byte_write,
	input  wire logic              byte_count_write,
	input  wire logic              sof_pulse,
	input  wire logic              in_token,
	input  wire logic              usb_ack,
	input  wire logic              usb_abort,
	output logic                   in_reply,
	output logic                   in_reply_data,
	output logic                   in_reply_zlp,
	output logic                   in_reply_nak,
	output logic                   in_reply_slot,
	output logic [1:0]             tx_data_set_index,
	output logic                   irq
);

	fill_if fill ();

	fill_counter u_fill (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.port    (fill.cnt)
	);

	// Bus slave state
	logic              bus_ack;
	logic              wr_go;
	logic              rd_go;

	// Software controls and status
	logic              feature_enable;
	logic              iso_mode;
	logic              clear_strobe;
	logic [SIZE_W-1:0] fifo_size;
	logic [IRQ_W-1:0]  irq_stat;
	logic [IRQ_W-1:0]  irq_mask;
	logic [IRQ_W-1:0]  irq_event;
	logic [IRQ_W-1:0]  irq_clear;
	logic              tx_overrun_flag;
	logic              tx_underrun_flag;

	// Data-set slots
	logic [SLOTS-1:0]  present;
	logic [SLOTS-1:0]  visible;
	logic [SLOTS-1:0]  late;
	logic [SLOTS-1:0]  release_pend;
	logic [SLOTS-1:0]  discard_hit;
	logic              wr_slot;
	logic              rd_slot;
	logic              frame_missed;

	// Events
	logic              count_ok;
	logic              overrun_evt;
	logic              ack_data;
	logic              rd_ready;
	logic              reply_is_data;
	logic              reply_slot_q;
	logic [7:0]        tx_flags_view;

	in_state_e         in_state;
	in_state_e         next_in_state;

	// Avalon-MM slave: one wait cycle, then the access completes
	assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;
	assign wr_go           = avs_write && bus_ack;
	assign rd_go           = avs_read && bus_ack;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= (avs_read || avs_write) && !bus_ack;
		end
	end

	// Flag register view
	assign tx_data_set_index = present;
	always_comb begin
		tx_flags_view                            = '0;
		tx_flags_view[FLG_INDEX_HI:FLG_INDEX_LO] = present;
		tx_flags_view[FLG_EMPTY]                 = fill.empty;
		tx_flags_view[FLG_FULL]                  = fill.full;
		tx_flags_view[FLG_UNDERRUN]              = tx_underrun_flag;
		tx_flags_view[FLG_OVERRUN]               = tx_overrun_flag;
	end

	// Read data registered in the wait cycle; unmapped reads give zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			avs_readdata <= '0;
		end else if (avs_read && !bus_ack) begin
			case (avs_address)
				OFF_FLAGS: begin
					avs_readdata <= {24'h000000, tx_flags_view};
				end
				OFF_CTRL: begin
					avs_readdata <= '0;
					avs_readdata[CTL_FEATURE] <= feature_enable;
					avs_readdata[CTL_ISO] <= iso_mode;
					avs_readdata[CTL_SIZE_LO +: SIZE_W] <= fifo_size;
				end
				OFF_IRQ_STAT: begin
					avs_readdata <= {{(32-IRQ_W){1'b0}}, irq_stat};
				end
				OFF_IRQ_MASK: begin
					avs_readdata <= {{(32-IRQ_W){1'b0}}, irq_mask};
				end
				default: begin
					avs_readdata <= '0;
				end
			endcase
		end
	end

	// Control register; the flag register ignores writes
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			feature_enable <= 1'b0;
			iso_mode       <= 1'b0;
			fifo_size      <= SIZE_RESET;
		end else if (wr_go && avs_address == OFF_CTRL) begin
			feature_enable <= avs_writedata[CTL_FEATURE];
			iso_mode       <= avs_writedata[CTL_ISO];
			fifo_size      <= avs_writedata[CTL_SIZE_LO +: SIZE_W];
		end
	end

	assign clear_strobe = wr_go && avs_address == OFF_CTRL && avs_writedata[CTL_CLEAR];

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_mask <= IRQ_RESET;
		end else if (wr_go && avs_address == OFF_IRQ_MASK) begin
			irq_mask <= avs_writedata[IRQ_W-1:0];
		end
	end

	// Sticky status, write one to clear, set wins
	assign irq_clear = (wr_go && avs_address == OFF_IRQ_STAT) ? avs_writedata[IRQ_W-1:0] : '0;
	always_comb begin
		irq_event               = '0;
		irq_event[IRQ_OVERRUN]  = overrun_evt;
		irq_event[IRQ_SET_DONE] = count_ok;
		irq_event[IRQ_DISCARD]  = |discard_hit;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_stat <= IRQ_RESET;
		end else begin
			irq_stat <= (irq_stat & ~irq_clear) | irq_event;
		end
	end

	assign irq = |(irq_stat & irq_mask);

	// Fill counter hookup
	assign fill.byte_write = fifo_byte_write;
	assign fill.restart    = count_ok || clear_strobe;
	assign fill.fifo_size  = fifo_size;

	// Set completion; refused while both sets are held
	assign count_ok    = byte_count_write && present != INDEX_BOTH;
	assign overrun_evt = (byte_count_write && present == INDEX_BOTH)
		|| (fifo_byte_write && fill.full);

	// Overrun flag, cleared by control strobe, set wins
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tx_overrun_flag <= 1'b0;
		end else if (overrun_evt) begin
			tx_overrun_flag <= 1'b1;
		end else if (clear_strobe) begin
			tx_overrun_flag <= 1'b0;
		end
	end

	// Underrun is handled elsewhere; this bit stays clear here
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tx_underrun_flag <= 1'b0;
		end else begin
			tx_underrun_flag <= 1'b0;
		end
	end

	// Per-slot state
	genvar gi;
	generate
		for (gi = 0; gi < SLOTS; gi++) begin : g_slot
			logic set_here;
			logic rel_here;
			assign set_here = count_ok && (wr_slot == 1'(gi));
			assign rel_here = ack_data && (reply_slot_q == 1'(gi));
			// Late set dropped at an SOF once visible with a newer set behind it
			assign discard_hit[gi] = sof_pulse && late[gi] && visible[gi] && present[gi]
				&& present[SLOTS-1-gi] && !release_pend[gi];

			always_ff @(posedge ref_clk) begin
				if (!rst_n || clear_strobe) begin
					present[gi] <= 1'b0;
				end else if (set_here) begin
					present[gi] <= 1'b1;
				end else if (discard_hit[gi]) begin
					present[gi] <= 1'b0;
				end else if (rel_here && !iso_mode) begin
					present[gi] <= 1'b0;
				end else if (sof_pulse && release_pend[gi]) begin
					present[gi] <= 1'b0;
				end
			end

			always_ff @(posedge ref_clk) begin
				if (!rst_n || clear_strobe) begin
					visible[gi] <= 1'b0;
				end else if (set_here) begin
					visible[gi] <= !feature_enable;
				end else if (!present[gi]) begin
					visible[gi] <= 1'b0;
				end else if (sof_pulse) begin
					visible[gi] <= 1'b1;
				end
			end

			always_ff @(posedge ref_clk) begin
				if (!rst_n || clear_strobe) begin
					late[gi] <= 1'b0;
				end else if (set_here) begin
					late[gi] <= feature_enable && frame_missed;
				end else if (!present[gi]) begin
					late[gi] <= 1'b0;
				end
			end

			always_ff @(posedge ref_clk) begin
				if (!rst_n || clear_strobe) begin
					release_pend[gi] <= 1'b0;
				end else if (rel_here && iso_mode) begin
					release_pend[gi] <= 1'b1;
				end else if (sof_pulse) begin
					release_pend[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Frame got no data at its SOF; a set finished now is late
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			frame_missed <= 1'b0;
		end else if (sof_pulse) begin
			frame_missed <= !(|(present & ~release_pend));
		end else if (count_ok) begin
			frame_missed <= 1'b0;
		end
	end

	// Slot pointers
	always_ff @(posedge ref_clk) begin
		if (!rst_n || clear_strobe) begin
			wr_slot <= 1'b0;
		end else if (count_ok) begin
			wr_slot <= !wr_slot;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n || clear_strobe) begin
			rd_slot <= 1'b0;
		end else if (ack_data || discard_hit[rd_slot]) begin
			rd_slot <= !rd_slot;
		end
	end

	// Oldest set ready for the host
	assign rd_ready = present[rd_slot] && visible[rd_slot] && !release_pend[rd_slot];

	// IN transaction handler
	always_comb begin
		next_in_state = in_state;
		case (in_state)
			IN_IDLE: begin
				if (in_token) begin
					next_in_state = IN_REPLY;
				end
			end
			IN_REPLY: begin
				next_in_state = reply_is_data ? IN_WAIT : IN_IDLE;
			end
			IN_WAIT: begin
				if (usb_ack || usb_abort) begin
					next_in_state = IN_IDLE;
				end
			end
			default: begin
				next_in_state = IN_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			in_state <= IN_IDLE;
		end else begin
			in_state <= next_in_state;
		end
	end

	assign ack_data = in_state == IN_WAIT && usb_ack;

	// Reply decision taken as the token arrives
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			in_reply      <= 1'b0;
			in_reply_data <= 1'b0;
			in_reply_zlp  <= 1'b0;
			in_reply_nak  <= 1'b0;
			in_reply_slot <= 1'b0;
			reply_is_data <= 1'b0;
			reply_slot_q  <= 1'b0;
		end else if (in_state == IN_IDLE && in_token) begin
			in_reply      <= 1'b1;
			in_reply_data <= rd_ready && !tx_overrun_flag;
			in_reply_zlp  <= !rd_ready && (feature_enable || iso_mode) && !tx_overrun_flag;
			in_reply_nak  <= !rd_ready && !(feature_enable || iso_mode) || tx_overrun_flag;
			in_reply_slot <= rd_slot;
			reply_is_data <= rd_ready && !tx_overrun_flag;
			reply_slot_q  <= rd_slot;
		end else begin
			in_reply      <= 1'b0;
			in_reply_data <= 1'b0;
			in_reply_zlp  <= 1'b0;
			in_reply_nak  <= 1'b0;
		end
	end

endmodule

/* File: design/tx_flags_pkg.sv */
// Constants, register map and types for the transmit FIFO status block
package tx_flags_pkg;

	// Register byte offsets on the Avalon bus
	localparam int            ADDR_W         = 8;
	localparam logic [7:0]    OFF_FLAGS      = 8'h04;
	localparam logic [7:0]    OFF_CTRL       = 8'h08;
	localparam logic [7:0]    OFF_IRQ_STAT   = 8'h0c;
	localparam logic [7:0]    OFF_IRQ_MASK   = 8'h10;

	// Transmit flag register layout
	localparam logic [7:0]    FLAGS_RESET    = 8'h08;
	localparam int            FLG_INDEX_HI   = 7;
	localparam int            FLG_INDEX_LO   = 6;
	localparam int            FLG_RSVD_HI    = 5;
	localparam int            FLG_RSVD_LO    = 4;
	localparam int            FLG_EMPTY      = 3;
	localparam int            FLG_FULL       = 2;
	localparam int            FLG_UNDERRUN   = 1;
	localparam int            FLG_OVERRUN    = 0;
	localparam logic [1:0]    INDEX_BOTH     = 2'h3;

	// Control register layout
	localparam int            CTL_FEATURE    = 0;
	localparam int            CTL_ISO        = 1;
	localparam int            CTL_CLEAR      = 2;
	localparam int            CTL_SIZE_LO    = 16;
	localparam int            SIZE_W         = 11;
	localparam logic [10:0]   SIZE_RESET     = 11'h040;

	// Interrupt status and mask layout
	localparam int            IRQ_W          = 3;
	localparam int            IRQ_OVERRUN    = 0;
	localparam int            IRQ_SET_DONE   = 1;
	localparam int            IRQ_DISCARD    = 2;
	localparam logic [2:0]    IRQ_RESET      = 3'h0;

	// Number of data-set slots
	localparam int            SLOTS          = 2;

	// IN transaction handler states; one bit flips per step except WAIT to IDLE, which flips both
	typedef enum logic [1:0] {
		IN_IDLE  = 2'b00,
		IN_REPLY = 2'b01,
		IN_WAIT  = 2'b11
	} in_state_e;

endpackage

/* File: dv/tb_top.sv */
// Self-checking bench for the transmit flag block
`timescale 1ns/1ps
module tb_top;
	import tx_flags_pkg::*;
	logic ref_clk, rst_n, avs_read, avs_write, fifo_byte_write, byte_count_write, sof_pulse;
	logic avs_waitrequest, in_token, usb_ack, usb_abort, in_reply, in_reply_data, in_reply_zlp;
	logic in_reply_nak, in_reply_slot, irq;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [1:0] tx_data_set_index;
	int mismatches, num_checks, cycles, held, wp, rp, cnt, ovf, iso, kind, slot;
	int size = 64;
	tx_fifo_flags u_tx_fifo_flags (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .fifo_byte_write, .byte_count_write, .sof_pulse, .in_token,
		.usb_ack, .usb_abort, .in_reply, .in_reply_data, .in_reply_zlp, .in_reply_nak, .in_reply_slot,
		.tx_data_set_index, .irq);
	usb_host_model u_host (.ref_clk, .in_reply, .in_reply_data, .in_reply_zlp, .in_reply_nak,
		.in_reply_slot, .in_token, .usb_ack, .usb_abort);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 0;
		avs_read <= 0;
	endtask
	task automatic cf;
		bus(0, OFF_FLAGS, 0);
		chk(q, {24'h0, held[1:0], 2'h0, cnt == 0, cnt >= size, 1'b0, ovf[0]});
	endtask
	task automatic hit(input int k);
		@(posedge ref_clk);
		{sof_pulse, byte_count_write, fifo_byte_write} <= 3'(k);
		@(posedge ref_clk);
		{sof_pulse, byte_count_write, fifo_byte_write} <= 3'h0;
	endtask
	task automatic wr_bytes(input int m);
		repeat (m) begin
			hit(1);
			if (cnt >= size) ovf = 1;
			else cnt++;
		end
	endtask
	task automatic done;
		hit(2);
		if (held == 3) ovf = 1;
		else begin
			held |= 1 << wp;
			wp ^= 1;
			cnt = 0;
		end
	endtask
	task automatic clr(input int c);
		bus(1, OFF_CTRL, (size << 16) | c | 4);
		iso = (c >> 1) & 1;
		{held, wp, rp, cnt, ovf} = 0;
	endtask
	task automatic in_chk(input bit ack, input int ek, input int es);
		u_host.xfer(ack, $urandom_range(0, 3), kind, slot);
		chk(kind, ek);
		if (ek == 1) chk(slot, es);
		if (ek == 1 && ack) begin
			if (!iso) held &= ~(1 << rp);
			rp ^= 1;
		end
	endtask
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		ref_clk = 0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			final_report;
		end
	end
	initial begin
		{rst_n, avs_read, avs_write, fifo_byte_write, byte_count_write, sof_pulse} = 0;
		avs_address = 0;
		avs_writedata = 0;
		void'($urandom(5));
		repeat (12) @(posedge ref_clk);
		rst_n <= 1;
		// Reset values, read-only and unmapped places
		cf;
		bus(0, OFF_CTRL, 0);
		chk(q, 32'h0040_0000);
		bus(0, 8'h20, 0);
		chk(q, 0);
		bus(1, OFF_FLAGS, 32'hff);
		cf;
		tend("reset");
		// Fill past the size limit
		size = 4;
		clr(0);
		for (int i = 0; i < 6; i++) begin
			wr_bytes(1);
			cf;
		end
		tend("fill");
		// Immediate visibility, overrun on third set, interrupt
		clr(0);
		wr_bytes($urandom_range(1, 4));
		done;
		cf;
		in_chk(0, 1, 0);
		in_chk(1, 1, 0);
		cf;
		done;
		done;
		done;
		cf;
		in_chk(1, 3, 0);
		bus(0, OFF_IRQ_STAT, 0);
		chk(q, 3);
		chk(irq, 0);
		bus(1, OFF_IRQ_MASK, 1);
		#1 chk(irq, 1);
		bus(1, OFF_IRQ_STAT, 7);
		#1 chk(irq, 0);
		bus(0, OFF_IRQ_STAT, 0);
		chk(q, 0);
		tend("direct");
		// Frame deferred visibility, firmware keeps single-packet use
		clr(1);
		wr_bytes(2);
		done;
		in_chk(1, 2, 0);
		hit(4);
		in_chk(1, 1, 0);
		cf;
		// Late set, then the correct one in the next frame
		hit(4);
		wr_bytes(1);
		done;
		in_chk(1, 2, 0);
		wr_bytes(1);
		done;
		hit(4);
		hit(4);
		held &= ~(1 << rp);
		rp ^= 1;
		cf;
		bus(0, OFF_IRQ_STAT, 0);
		chk(q[2], 1);
		in_chk(1, 1, 0);
		tend("frame");
		// Isochronous release waits for start of frame
		clr(2);
		done;
		in_chk(1, 1, 0);
		cf;
		hit(4);
		held = 0;
		cf;
		tend("iso");
		final_report;
	end
endmodule

/* File: dv/tx_flags_props.sv */
// Assertion checker for the transmit flag block
`timescale 1ns/1ps
module tx_flags_props
	import tx_flags_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              rst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic [31:0]       avs_readdata,
	input wire logic              avs_waitrequest,
	input wire logic              byte_count_write,
	input wire logic              sof_pulse,
	input wire logic              in_token,
	input wire logic              usb_ack,
	input wire logic              in_reply,
	input wire logic              in_reply_data,
	input wire logic              in_reply_zlp,
	input wire logic              in_reply_nak,
	input wire logic [1:0]        tx_data_set_index
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_flag_rd;
		avs_read && !avs_waitrequest && avs_address == OFF_FLAGS;
	endsequence
	sequence s_done(logic [1:0] v);
		byte_count_write && tx_data_set_index == v && !usb_ack && !sof_pulse && !avs_write;
	endsequence
	a_wait_once: assert property (s_req |=> !avs_waitrequest)
		else $error("wait state longer than one cycle");
	a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait without request");
	a_rsvd_zero: assert property (s_flag_rd |-> avs_readdata[5:4] == 2'h0 && avs_readdata[31:8] == 24'h0)
		else $error("reserved flag bits not zero");
	a_index_read: assert property (s_flag_rd |-> avs_readdata[7:6] == $past(tx_data_set_index))
		else $error("index field differs from index");
	a_index_full: assert property (s_done(INDEX_BOTH) |=> tx_data_set_index == INDEX_BOTH)
		else $error("index left full state");
	a_index_add: assert property (s_done(2'h0) |=> $countones(tx_data_set_index) == 1)
		else $error("completed set not counted at once");
	a_reply_cause: assert property (in_reply |-> $past(in_token))
		else $error("reply without token");
	a_reply_kind: assert property (in_reply |-> $onehot({in_reply_data, in_reply_zlp, in_reply_nak}))
		else $error("reply kind not unique");
	a_data_held: assert property (in_reply && in_reply_data |-> $past(tx_data_set_index) != 2'h0)
		else $error("data sent with no set held");
	a_index_cause: assert property ($changed(tx_data_set_index) |->
		$past(byte_count_write || usb_ack || sof_pulse || avs_write))
		else $error("index changed without cause");
endmodule
bind tx_fifo_flags tx_flags_props u_props (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .byte_count_write, .sof_pulse, .in_token, .usb_ack, .in_reply,
	.in_reply_data, .in_reply_zlp, .in_reply_nak, .tx_data_set_index);

/* File: dv/usb_host_model.sv */
// Host side model issuing IN tokens and acknowledging data
`timescale 1ns/1ps
module usb_host_model (
	input  wire logic ref_clk,
	input  wire logic in_reply,
	input  wire logic in_reply_data,
	input  wire logic in_reply_zlp,
	input  wire logic in_reply_nak,
	input  wire logic in_reply_slot,
	output logic      in_token,
	output logic      usb_ack,
	output logic      usb_abort
);
	initial begin
		in_token = 0;
		usb_ack = 0;
		usb_abort = 0;
	end
	task automatic xfer(input bit ack, input int wt, output int kind, output int slot);
		@(posedge ref_clk);
		in_token <= 1;
		@(posedge ref_clk);
		in_token <= 0;
		for (int n = 0; n < 8 && in_reply !== 1'b1; n++)
			@(posedge ref_clk);
		kind = in_reply_data ? 1 : in_reply_zlp ? 2 : in_reply_nak ? 3 : 0;
		slot = in_reply_slot;
		if (kind == 1) begin
			repeat (wt) @(posedge ref_clk);
			usb_ack <= ack;
			usb_abort <= !ack;
			@(posedge ref_clk);
			usb_ack <= 0;
			usb_abort <= 0;
		end
	endtask
endmodule
